/* core/slmc_pkg.sv */
// shared constants and types of the sleep mode controller
package slmc_pkg;
   // register indices; byte address is four times the index
   localparam logic [7:0] MCU_CONTROL_IDX = 8'h35;
   localparam logic [7:0] SLEEP_STATUS_IDX = 8'h36;
   localparam logic [7:0] MCU_CONTROL_ADR = {MCU_CONTROL_IDX[5:0], 2'b00};
   localparam logic [7:0] SLEEP_STATUS_ADR = {SLEEP_STATUS_IDX[5:0], 2'b00};
   localparam logic [7:0] MCU_CONTROL_RST = 8'h00;
   // mcu_control field positions
   localparam int ARM_BIT = 5;
   localparam int SEL1_BIT = 4;
   localparam int SEL0_BIT = 3;
   localparam int SEL2_BIT = 2;
   // sleep_status field positions
   localparam int STAT_STATE_LSB = 0;
   localparam int STAT_MODE_LSB = 4;
   // low_power_select codes
   localparam logic [2:0] MODE_IDLE = 3'h0;
   localparam logic [2:0] MODE_NOISE = 3'h1;
   localparam logic [2:0] MODE_PDOWN = 3'h2;
   localparam logic [2:0] MODE_PSAVE = 3'h3;
   localparam logic [2:0] MODE_RES4 = 3'h4;
   localparam logic [2:0] MODE_RES5 = 3'h5;
   localparam logic [2:0] MODE_STBY = 3'h6;
   localparam logic [2:0] MODE_XSTBY = 3'h7;
   // clock gate vector bit positions
   localparam int G_CPU = 6;
   localparam int G_FLASH = 5;
   localparam int G_IO = 4;
   localparam int G_ADC = 3;
   localparam int G_ASY = 2;
   localparam int G_OSC = 1;
   localparam int G_TOSC = 0;
   localparam logic [6:0] GATES_RUN = 7'h7E;
   // cycle counts of the wake-up sequence
   localparam logic [15:0] IRQ_HOLD_CYCLES = 16'h0004;
   localparam logic [15:0] STBY_WAKE_CYCLES = 16'h0006;
   // sequencer states
   typedef enum logic [3:0] {
      ST_RUN = 4'b0001,
      ST_SLEEP = 4'b0010,
      ST_START = 4'b0100,
      ST_HOLD = 4'b1000
   } slmc_state_t;
endpackage

/* core/slmc_sleep_ctrl.sv */
// sleep mode sequencer with clock gating and wake qualification
`timescale 1ns/100ps
// Notes on behaviour
// - sleep is entered only on a halt request while the arm bit is one.
// - interrupt wake stalls four cycles after start-up, then runs handler.
// - register file and memory are kept; clocks only stop, nothing clears.
// - any reset during sleep wakes to the reset vector.
// - control holds arm at bit 5, select bits 4..2 as sel1,sel0,sel2.
// - select codes: idle, noise, pdown, psave, standby, ext standby.
// - standby modes exist only with a crystal main clock.
// - idle stops only the cpu and flash clocks.
// - idle wakes on any external or internal interrupt.
// - idle or noise entry with converter on starts a conversion.
// - noise mode stops io, cpu and flash clocks.
// - noise mode wakes only on its listed sources.
// - power-down stops the oscillator and every generated clock.
// - power-down wakes only on two-wire match, external low group and level interrupts.
// - power-down wake waits the fuse-defined start-up period.
// - power-save keeps async timer 0 and may wake on it.
// - power-save without async timer 0 leaves timer contents undefined.
// - standby is power-down with oscillator on, wakes in six cycles.
// - extended standby is power-save with oscillator on, six cycles.
module slmc_sleep_ctrl
   import slmc_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // cpu core
   input wire logic haltReq,
   output logic cpuStall,
   output logic irqResume,
   output logic resetVector,
   // reset sources and fuses
   input wire logic resetReq,
   input wire logic xtalSource,
   input wire logic [15:0] startupCycles,
   // wake event sources, each already enable-qualified
   input wire logic [3:0] extIrqLowGroup,
   input wire logic [3:0] extIrqHighGroup,
   input wire logic [3:0] extLevelHighGroup,
   input wire logic twoWireMatch,
   input wire logic adcDone,
   input wire logic selfProgramReady,
   input wire logic otherIoIrq,
   // timer 0 and global enable
   input wire logic timer0AsyncSelect,
   input wire logic timer0Ovf,
   input wire logic timer0Cmp,
   input wire logic timer0OvfMask,
   input wire logic timer0CmpMask,
   input wire logic globalIrqEn,
   // converter
   input wire logic adcEnabled,
   output logic adcStart,
   // clock domain enables
   output logic clkEnCpu,
   output logic clkEnFlash,
   output logic clkEnIo,
   output logic clkEnAdc,
   output logic clkEnAsy,
   output logic mainOscEn,
   output logic timerOscEn
);
   slmc_state_t state_r;
   slmc_state_t state_nxt;
   logic [2:0] effMode_r;
   logic [2:0] effMode_nxt;
   logic [7:0] mcuControl;
   logic [2:0] selCode;
   logic arm;
   logic enter;
   logic wakeHit;
   logic t0Wake;
   logic tmrLoad;
   logic [15:0] tmrVal;
   logic tmrExpire;
   logic [6:0] gates_r;
   logic [6:0] gates_nxt;

   ////////////////////////////////////////////////////////////////////
   // mode decode helpers

   // reserved codes fall back to idle; standby needs a crystal
   function automatic logic [2:0] resolveMode(input logic [2:0] code,
                                              input logic xtal);
      logic [2:0] m;
      m = code;
      if (code == MODE_RES4 || code == MODE_RES5) begin
         m = MODE_IDLE;
      end else if (code == MODE_STBY && !xtal) begin
         m = MODE_PDOWN;
      end else if (code == MODE_XSTBY && !xtal) begin
         m = MODE_PSAVE;
      end
      return m;
   endfunction

   // clock domains left running in each sleep mode
   function automatic logic [6:0] sleepGates(input logic [2:0] m,
                                             input logic as0);
      logic [6:0] g;
      g = 7'h00;
      case (m)
         MODE_IDLE: begin
            g = GATES_RUN;
            g[G_CPU] = 1'b0;
            g[G_FLASH] = 1'b0;
            g[G_TOSC] = as0;
         end
         MODE_NOISE: begin
            g[G_ADC] = 1'b1;
            g[G_ASY] = 1'b1;
            g[G_OSC] = 1'b1;
            g[G_TOSC] = as0;
         end
         MODE_PDOWN: begin
            g = 7'h00;
         end
         MODE_PSAVE: begin
            // timer contents undefined if as0 is low here
            g[G_ASY] = as0;
            g[G_TOSC] = as0;
         end
         MODE_STBY: begin
            g[G_OSC] = 1'b1;
         end
         MODE_XSTBY: begin
            g[G_ASY] = as0;
            g[G_TOSC] = as0;
            g[G_OSC] = 1'b1;
         end
         default: begin
            g = GATES_RUN;
         end
      endcase
      return g;
   endfunction

   // register bus
   slmc_wb_regs u_regs (
      .clk(clk),
      .reset_n(reset_n),
      .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o),
      .swReset(resetReq),
      .statusRd({1'b0, effMode_r, state_r}),
      .mcuControl(mcuControl)
   );

   // field split of the control register
   assign arm = mcuControl[ARM_BIT];
   assign selCode = {mcuControl[SEL2_BIT], mcuControl[SEL1_BIT],
                     mcuControl[SEL0_BIT]};
   assign enter = (state_r == ST_RUN) && haltReq && arm &&
                  !resetReq;

   ////////////////////////////////////////////////////////////////////
   // wake qualification

   assign t0Wake = globalIrqEn && ((timer0Ovf && timer0OvfMask) ||
                                   (timer0Cmp && timer0CmpMask));

   always_comb begin
      wakeHit = 1'b0;
      case (effMode_r)
         MODE_IDLE: begin
            wakeHit = (|extIrqLowGroup) || (|extIrqHighGroup) ||
                      twoWireMatch || adcDone || selfProgramReady ||
                      otherIoIrq || t0Wake || (|extLevelHighGroup);
         end
         MODE_NOISE: begin
            wakeHit = adcDone || twoWireMatch || t0Wake ||
                      selfProgramReady || (|extLevelHighGroup) ||
                      (|extIrqLowGroup);
         end
         MODE_PDOWN, MODE_STBY: begin
            wakeHit = twoWireMatch || (|extLevelHighGroup) ||
                      (|extIrqLowGroup);
         end
         MODE_PSAVE, MODE_XSTBY: begin
            wakeHit = twoWireMatch || (|extLevelHighGroup) ||
                      (|extIrqLowGroup) ||
                      (timer0AsyncSelect && t0Wake);
         end
         default: begin
            wakeHit = 1'b0;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // sequencer

   // reset requests override every phase of the sequence
   always_comb begin
      state_nxt = state_r;
      effMode_nxt = effMode_r;
      tmrLoad = 1'b0;
      tmrVal = IRQ_HOLD_CYCLES;
      case (state_r)
         ST_RUN: begin
            if (enter) begin
               state_nxt = ST_SLEEP;
               effMode_nxt = resolveMode(selCode, xtalSource);
            end
         end
         ST_SLEEP: begin
            if (resetReq) begin
               state_nxt = ST_RUN;
            end else if (wakeHit) begin
               if (effMode_r == MODE_STBY || effMode_r == MODE_XSTBY) begin
                  state_nxt = ST_START;
                  tmrLoad = 1'b1;
                  tmrVal = STBY_WAKE_CYCLES;
               end else if ((effMode_r == MODE_PDOWN ||
                             effMode_r == MODE_PSAVE) &&
                            startupCycles != 16'h0000) begin
                  state_nxt = ST_START;
                  tmrLoad = 1'b1;
                  tmrVal = startupCycles;
               end else begin
                  state_nxt = ST_HOLD;
                  tmrLoad = 1'b1;
               end
            end
         end
         ST_START: begin
            if (resetReq) begin
               state_nxt = ST_RUN;
            end else if (tmrExpire) begin
               state_nxt = ST_HOLD;
               tmrLoad = 1'b1;
            end
         end
         ST_HOLD: begin
            if (resetReq) begin
               state_nxt = ST_RUN;
            end else if (tmrExpire) begin
               state_nxt = ST_RUN;
            end
         end
         default: begin
            state_nxt = ST_RUN;
         end
      endcase
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_r <= ST_RUN;
         effMode_r <= MODE_IDLE;
      end else begin
         state_r <= state_nxt;
         effMode_r <= effMode_nxt;
      end
   end

   // start-up and hold phases share one counter
   slmc_wake_timer u_timer (
      .clk(clk),
      .reset_n(reset_n),
      .load(tmrLoad),
      .loadVal(tmrVal),
      .expire(tmrExpire),
      .busy()
   );

   ////////////////////////////////////////////////////////////////////
   // cpu side pulses and stall

   // cpu is stalled, never reset, so its state survives
   assign cpuStall = (state_r != ST_RUN);

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         irqResume <= 1'b0;
         resetVector <= 1'b0;
      end else begin
         irqResume <= (state_r == ST_HOLD) && tmrExpire &&
                      !resetReq;
         resetVector <= (state_r != ST_RUN) && resetReq;
      end
   end

   // conversion kick on entry; converter clock runs in both modes
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         adcStart <= 1'b0;
      end else begin
         adcStart <= enter && adcEnabled &&
                     (effMode_nxt == MODE_IDLE ||
                      effMode_nxt == MODE_NOISE);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // clock domain enables

   // during start-up only the oscillator returns; clocks wait for it
   always_comb begin
      gates_nxt = GATES_RUN;
      gates_nxt[G_TOSC] = timer0AsyncSelect;
      if (state_nxt == ST_SLEEP) begin
         gates_nxt = sleepGates(effMode_nxt, timer0AsyncSelect);
      end else if (state_nxt == ST_START) begin
         gates_nxt = sleepGates(effMode_nxt, timer0AsyncSelect);
         gates_nxt[G_OSC] = 1'b1;
      end
   end

   // gates come from flops so no enable glitches into a clock gate
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         gates_r <= GATES_RUN;
      end else begin
         gates_r <= gates_nxt;
      end
   end

   assign clkEnCpu = gates_r[G_CPU];
   assign clkEnFlash = gates_r[G_FLASH];
   assign clkEnIo = gates_r[G_IO];
   assign clkEnAdc = gates_r[G_ADC];
   assign clkEnAsy = gates_r[G_ASY];
   assign mainOscEn = gates_r[G_OSC];
   assign timerOscEn = gates_r[G_TOSC];

   ////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   a_disarmed_halt: assert property (
      (state_r == ST_RUN && haltReq && !arm) |=> state_r == ST_RUN)
      else $error("halt without arm entered sleep");

   a_armed_entry: assert property (
      enter |=> state_r == ST_SLEEP)
      else $error("armed halt did not enter sleep");

   a_hold_four: assert property (
      ($rose(state_r == ST_HOLD) ##0 (!resetReq)[*4]) |=> irqResume)
      else $error("handler not released after four hold cycles");

   a_reset_wake: assert property (
      (state_r != ST_RUN && resetReq) |=> state_r == ST_RUN && resetVector)
      else $error("reset in sleep did not go to reset vector");

   a_reserved_idle: assert property (
      (enter && selCode[2:1] == 2'b10) |=> effMode_r == MODE_IDLE)
      else $error("reserved code not treated as idle");

   a_stby_no_xtal: assert property (
      (enter && selCode == MODE_STBY && !xtalSource)
      |=> effMode_r == MODE_PDOWN)
      else $error("standby taken without crystal");

   a_idle_gates: assert property (
      (state_r == ST_SLEEP && effMode_r == MODE_IDLE)
      |-> !clkEnCpu && !clkEnFlash && clkEnIo && clkEnAdc)
      else $error("idle clock gating wrong");

   a_noise_gates: assert property (
      (state_r == ST_SLEEP && effMode_r == MODE_NOISE)
      |-> !clkEnIo && !clkEnCpu && clkEnAdc)
      else $error("noise mode clock gating wrong");

   a_pdown_gates: assert property (
      (state_r == ST_SLEEP && effMode_r == MODE_PDOWN)
      |-> !mainOscEn && !clkEnAsy && !clkEnIo)
      else $error("power-down left a clock running");

   a_pdown_stays: assert property (
      (state_r == ST_SLEEP && effMode_r == MODE_PDOWN && !resetReq &&
       !twoWireMatch && extIrqLowGroup == 4'h0 &&
       extLevelHighGroup == 4'h0) |=> state_r == ST_SLEEP)
      else $error("power-down woke on a foreign source");

   a_stby_six: assert property (
      ($rose(state_r == ST_START) && effMode_r == MODE_STBY
       ##0 (!resetReq)[*6]) |=> state_r == ST_HOLD)
      else $error("standby wake not six cycles");

   a_adc_kick: assert property (
      (enter && adcEnabled && selCode == MODE_NOISE) |=> adcStart)
      else $error("no conversion started on entry");

   c_idle_wake: cover property (
      state_r == ST_SLEEP && effMode_r == MODE_IDLE ##1 state_r == ST_HOLD);
   c_pdown_start: cover property (
      state_r == ST_START && effMode_r == MODE_PDOWN ##1 state_r == ST_HOLD);
   c_reset_wake: cover property (resetVector);
endmodule

/* core/slmc_wake_timer.sv */
// down counter timing start-up and interrupt hold phases
`timescale 1ns/100ps
module slmc_wake_timer
   import slmc_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // load request
   input wire logic load,
   input wire logic [15:0] loadVal,
   // status
   output logic expire,
   output logic busy
);
   logic [15:0] count_r;

   // reload wins over counting so a new phase always starts clean
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         count_r <= 16'h0000;
      end else if (load) begin
         count_r <= loadVal;
      end else if (count_r != 16'h0000) begin
         count_r <= count_r - 16'h0001;
      end
   end

   // last cycle of the loaded period
   assign expire = (count_r == 16'h0001);
   assign busy = (count_r != 16'h0000);
endmodule

/* core/slmc_wb_regs.sv */
// classic wishbone slave holding the control and status registers
`timescale 1ns/100ps
module slmc_wb_regs
   import slmc_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // block side
   input wire logic swReset,
   input wire logic [7:0] statusRd,
   output logic [7:0] mcuControl
);
   logic req;
   logic [7:0] rdMux;

   // one cycle answer; ack drops the cycle after it was given
   assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= req;
      end
   end

   // a device reset source clears the register like a power-up
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         mcuControl <= MCU_CONTROL_RST;
      end else if (swReset) begin
         mcuControl <= MCU_CONTROL_RST;
      end else if (wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i &&
                   wb_sel_i[0] && wb_adr_i == MCU_CONTROL_ADR) begin
         mcuControl <= wb_dat_i[7:0]; // lands where master sees ack
      end
   end

   // unmapped addresses answer with zero
   always_comb begin
      rdMux = 8'h00;
      if (wb_adr_i == MCU_CONTROL_ADR) begin
         rdMux = mcuControl;
      end else if (wb_adr_i == SLEEP_STATUS_ADR) begin
         rdMux = statusRd;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (req && !wb_we_i) begin
         wb_dat_o <= {24'h000000, rdMux};
      end
   end
endmodule

/* tb/slmc_cpu_model.sv */
// cpu core and wake source model facing the sleep controller
`timescale 1ns/100ps
module slmc_cpu_model (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // commands from the bench
   input wire logic doHalt,
   input wire logic wakeCmd,
   // controller answers
   input wire logic irqResume,
   input wire logic resetVector,
   // towards the controller
   output logic haltReq,
   output logic wakeLvl
);
   logic held_r;

   // halt lasts one cycle and follows the bench command doHalt directly
   assign haltReq = doHalt;

   // a level source stays up until the core resumes, so it is not missed
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         held_r <= 1'b0;
      end else if (irqResume || resetVector) begin
         held_r <= 1'b0;
      end else if (wakeCmd) begin
         held_r <= 1'b1;
      end
   end
   assign wakeLvl = held_r | wakeCmd;
endmodule

/* tb/testbench.sv */
// self-checking bench of the sleep mode controller
`timescale 1ns/100ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin \
   n_mismatch++; $display("Error %0t: got %0h expected %0h", $time, a, e); \
   end end
module testbench;
   import slmc_pkg::*;
   // wake input used per mode: other, adc, extlow, ovf, two-wire, cmp, level
   localparam logic [2:0] SRC [8] = '{3'h0, 3'h1, 3'h2, 3'h3,
      3'h0, 3'h6, 3'h4, 3'h5};
   logic clk, reset_n, cyc, stb, we, ack, resetReq, xtal, asel, adcEn;
   logic doHalt, wakeCmd, junk, haltReq, wakeLvl, cpuStall, irqResume;
   logic resetVector, adcStart, seen, x, a;
   logic [7:0] adr, q, v;
   logic [31:0] wdat, rdat;
   logic [3:0] sel;
   logic [15:0] st;
   logic [6:0] gates, srcVec;
   logic [2:0] src, m, e;
   int n_mismatch, n_compared, cycCnt, n, lat;

   // one wake input at a time, held by the partner
   assign srcVec = wakeLvl ? (7'h01 << src) : 7'h00;

   slmc_sleep_ctrl i_slmc_sleep_ctrl (
      .clk(clk), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .haltReq(haltReq),
      .cpuStall(cpuStall), .irqResume(irqResume),
      .resetVector(resetVector), .resetReq(resetReq), .xtalSource(xtal),
      .startupCycles(st), .extIrqLowGroup({3'h0, srcVec[2]}),
      .extIrqHighGroup({3'h0, junk}), .extLevelHighGroup({srcVec[6], 3'h0}),
      .twoWireMatch(srcVec[4]), .adcDone(srcVec[1]),
      .selfProgramReady(1'b0), .otherIoIrq(srcVec[0] | junk),
      .timer0AsyncSelect(asel), .timer0Ovf(srcVec[3]),
      .timer0Cmp(srcVec[5]), .timer0OvfMask(1'b1), .timer0CmpMask(1'b1),
      .globalIrqEn(1'b1), .adcEnabled(adcEn), .adcStart(adcStart),
      .clkEnCpu(gates[6]), .clkEnFlash(gates[5]), .clkEnIo(gates[4]),
      .clkEnAdc(gates[3]), .clkEnAsy(gates[2]), .mainOscEn(gates[1]),
      .timerOscEn(gates[0]));

   slmc_cpu_model i_slmc_cpu_model (
      .clk(clk), .reset_n(reset_n), .doHalt(doHalt), .wakeCmd(wakeCmd),
      .irqResume(irqResume), .resetVector(resetVector),
      .haltReq(haltReq), .wakeLvl(wakeLvl));

   ////////////////////////////////////////////////////////////////////////
   // reserved codes sleep as idle, standby without crystal as power-down
   function automatic logic [2:0] effMode(logic [2:0] c, logic xt);
      if (c == MODE_RES4 || c == MODE_RES5) return MODE_IDLE;
      if (c >= MODE_STBY && !xt) return c - 3'h4;
      return c;
   endfunction

   // clock enables {cpu,flash,io,adc,asy,osc,tosc} while asleep
   function automatic logic [6:0] expGates(logic [2:0] c, logic as);
      case (c)
         MODE_IDLE: return {6'h0F, as};
         MODE_NOISE: return {6'h07, as};
         MODE_PSAVE: return {4'h0, as, 1'b0, as};
         MODE_STBY: return 7'h02;
         MODE_XSTBY: return {4'h0, as, 1'b1, as};
         default: return 7'h00;
      endcase
   endfunction

   function automatic logic [7:0] ctl(logic arm, logic [2:0] c,
      logic [7:0] r);
      return {r[7:6], arm, c[1], c[0], c[2], r[1:0]};
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // classic single cycle, held until ack is sampled high
   task automatic wb(input logic w, input logic [7:0] ad,
      input logic [7:0] d, output logic [7:0] rd);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      sel <= 4'hF;
      adr <= ad;
      wdat <= {24'h0, d};
      // no limit of its own: the run ceiling ends a hung wait
      do begin
         @(posedge clk);
      end while (ack !== 1'b1);
      rd = rdat[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask

   // halt pulse, then watch for the converter start
   task automatic halt();
      @(posedge clk);
      doHalt <= 1'b1;
      @(posedge clk);
      doHalt <= 1'b0;
      seen = 1'b0;
      repeat (4) begin
         @(posedge clk);
         seen |= adcStart;
      end
   endtask

   task automatic done(input string s);
      $display("test %0s done", s);
   endtask

   task automatic finish_test();
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // run ceiling, far above the expected run of under one thousand cycles
   always @(posedge clk) begin
      cycCnt++;
      if (cycCnt == 20000) begin
         n_mismatch++;
         finish_test();
      end
   end

   initial begin
      {reset_n, cyc, stb, we, resetReq, doHalt, wakeCmd, junk} = '0;
      {xtal, asel, adcEn, adr, wdat, st, src} = '0;
      sel = 4'hF;
      void'($urandom(88862));
      repeat (3) @(posedge clk);
      reset_n <= 1'b1;
      wb(1'b0, MCU_CONTROL_ADR, 8'h00, q);
      `CHK(q, MCU_CONTROL_RST)
      wb(1'b1, 8'h10, 8'hFF, q);
      wb(1'b0, 8'h10, 8'h00, q);
      `CHK(q, 8'h00)
      done("registers");
      // disarmed halt is ignored
      wb(1'b1, MCU_CONTROL_ADR, ctl(1'b0, MODE_PDOWN, 8'h00), q);
      halt();
      `CHK(cpuStall, 1'b0)
      done("disarmed");
      // every select code, first with crystal, then at random
      for (int i = 0; i < 24; i++) begin
         m = i[2:0];
         x = (i < 8) ? 1'b1 : 1'($urandom % 2);
         e = effMode(m, x);
         a = (e == MODE_PSAVE || e == MODE_XSTBY) | 1'($urandom % 2);
         st <= 16'h2 + 16'($urandom % 8);
         lat = (e <= MODE_NOISE) ? 0 : (e >= MODE_STBY) ? 6 : -1;
         xtal <= x;
         asel <= a;
         adcEn <= 1'($urandom % 2);
         src <= SRC[(e == MODE_IDLE) ? m : e];
         v = ctl(1'b1, m, 8'($urandom));
         wb(1'b1, MCU_CONTROL_ADR, v, q);
         wb(1'b0, MCU_CONTROL_ADR, 8'h00, q);
         `CHK(q, v)
         if (lat < 0) lat = int'(st);
         halt();
         `CHK(seen, adcEn && e <= MODE_NOISE)
         `CHK(cpuStall, 1'b1)
         `CHK(gates[6:3], expGates(e,a)>>3)
         `CHK(gates[2:0], expGates(e, a) & 7'h07)
         // a source outside the mode's list must not wake
         if (e != MODE_IDLE) begin
            junk <= 1'b1;
            repeat (4) @(posedge clk);
            junk <= 1'b0;
            `CHK(cpuStall, 1'b1)
         end
         wakeCmd <= 1'b1;
         n = 0;
         do begin
            @(posedge clk);
            wakeCmd <= 1'b0;
            n++;
         end while (irqResume !== 1'b1 && n < 40);
         `CHK(n, 6 + lat)
         `CHK(cpuStall, 1'b0)
         `CHK(gates[6:1], 6'h3F)
         wb(1'b1, MCU_CONTROL_ADR, 8'h00, q);
         done("mode");
      end
      // device reset while in power-down
      wb(1'b1, MCU_CONTROL_ADR, ctl(1'b1, MODE_PDOWN, 8'hC3), q);
      halt();
      resetReq <= 1'b1;
      seen = 1'b0;
      repeat (3) begin
         @(posedge clk);
         resetReq <= 1'b0;
         seen |= resetVector;
      end
      `CHK(seen, 1'b1)
      `CHK(cpuStall, 1'b0)
      wb(1'b0, MCU_CONTROL_ADR, 8'h00, q);
      `CHK(q, 8'h00)
      done("reset in sleep");
      finish_test();
   end
endmodule
